/* File: mode_pkg.sv */
// Purpose: shared constants and types for the operating mode selector
// Assumes: apb register word per offset, 8-bit mode register in the low byte
// Notes: mode code is {special_mode_n, mode_select_b, mode_select_a}
package mode_pkg;

   // register byte offsets
   localparam logic [11:0] MODE_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;

   // mode register field positions
   localparam int SPECIAL_MODE_N_BIT = 7;
   localparam int MODE_SELECT_B_BIT = 6;
   localparam int MODE_SELECT_A_BIT = 5;
   localparam int ESTR_BIT = 4;
   localparam int IVIS_BIT = 3;
   localparam int EBSWAI_BIT = 2;
   localparam int EMK_BIT = 1;
   localparam int EME_BIT = 0;

   // mode register values, mode bits ored in at capture
   localparam logic [7:0] MODE_PRE_CAPTURE = 8'h00;
   localparam logic [7:0] MODE_RST_SPECIAL = 8'h1B;
   localparam logic [7:0] MODE_RST_NORMAL = 8'h10;

   // mode select code that software may never write
   localparam logic [1:0] MOD_FORBIDDEN = 2'h2;

   // status register field positions
   localparam int ST_SPECIAL_BIT = 0;
   localparam int ST_SINGLE_BIT = 1;
   localparam int ST_NARROW_BIT = 2;
   localparam int ST_WIDE_BIT = 3;
   localparam int ST_PERIPH_BIT = 4;
   localparam int ST_AB_MAP_BIT = 5;
   localparam int ST_E_MAP_BIT = 6;
   localparam int ST_K_MAP_BIT = 7;
   localparam int ST_DBG_EN_BIT = 8;
   localparam int ST_DBG_ACT_BIT = 9;

   typedef enum logic [2:0] {
      SPECIAL_SINGLE,
      SPECIAL_NARROW,
      SPECIAL_PERIPH,
      SPECIAL_WIDE,
      NORMAL_SINGLE,
      NORMAL_NARROW,
      NORMAL_RESERVED,
      NORMAL_WIDE
   } mode_t;

   // decoded configuration of the current mode
   typedef struct packed {
      mode_t mode;
      logic special;
      logic single_chip;
      logic narrow;
      logic wide;
      logic peripheral;
      logic port_a_bus;
      logic port_b_addr;
      logic port_b_data;
   } cfg_t;

endpackage

/* File: strap_sync.sv */
// Purpose: two flip-flop synchroniser for a group of pin levels
// Assumes: pins are quasi static, no word coherence needed
// Notes: stage one feeds stage two only
module strap_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins and synchronised copy
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);

   logic [WIDTH-1:0] meta_q;

   // two stage shift toward the clock domain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         pin_sync <= '0;
      end else begin
         meta_q <= pin_in;
         pin_sync <= meta_q;
      end
   end

endmodule

/* File: mode_decode.sv */
// Purpose: decode a 3-bit mode code into the bus configuration
// Assumes: code is {special_mode_n, mode_select_b, mode_select_a}
// Notes: purely combinational
module mode_decode (
   // mode code in
   input wire logic [2:0] code,
   // decoded configuration
   output mode_pkg::cfg_t cfg
);

   // eight codes, reserved forced to peripheral
   always_comb begin
      cfg = '0;
      case (code)
         3'h0: cfg.mode = mode_pkg::SPECIAL_SINGLE;
         3'h1: cfg.mode = mode_pkg::SPECIAL_NARROW;
         3'h2: cfg.mode = mode_pkg::SPECIAL_PERIPH;
         3'h3: cfg.mode = mode_pkg::SPECIAL_WIDE;
         3'h4: cfg.mode = mode_pkg::NORMAL_SINGLE;
         3'h5: cfg.mode = mode_pkg::NORMAL_NARROW;
         3'h6: cfg.mode = mode_pkg::NORMAL_RESERVED;
         default: cfg.mode = mode_pkg::NORMAL_WIDE;
      endcase
      cfg.special = ~code[2];
      cfg.single_chip = (code[1:0] == 2'h0);
      cfg.narrow = (code[1:0] == 2'h1);
      cfg.wide = (code[1:0] == 2'h3);
      cfg.peripheral = (code[1:0] == 2'h2);
      // bus use of ports A and B
      cfg.port_a_bus = ~cfg.single_chip;
      cfg.port_b_addr = ~cfg.single_chip;
      cfg.port_b_data = cfg.wide | cfg.peripheral;
   end

endmodule

/* File: operating_mode_select.sv */
// Purpose: operating mode capture, mode register and map/bus configuration
// Assumes: apb slave with one answer cycle, 125 MHz clk, straps from pins
// Notes: configuration outputs follow the mode register one cycle later
//
// Added by the designer: the address map and the APB interface to the registers.
module operating_mode_select #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // strap pins
   input wire logic debug_strap_pin,
   input wire logic mode_select_b,
   input wire logic mode_select_a,
   // debug host commands, one-cycle pulses on clk
   input wire logic debug_enable_cmd,
   input wire logic debug_activate_cmd,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // mode and configuration
   output logic [7:0] mode_reg,
   output mode_pkg::cfg_t cfg_out,
   output logic port_ab_in_map,
   output logic port_e_in_map,
   output logic port_k_in_map,
   output logic mode_reg_in_map,
   output logic regs_protected,
   output logic background_debug_mode
);

   logic rst_meta_q;
   logic rst_sync_q;
   logic [2:0] strap_s;
   logic [7:0] mode_q, mode_d;
   logic captured_q, captured_d;
   logic [1:0] settle_q, settle_d;
   logic wr_seen_q, wr_seen_d;
   logic dbg_en_q, dbg_en_d;
   logic dbg_act_q, dbg_act_d;
   mode_pkg::cfg_t cfg_now, cfg_q;
   logic ab_map_q, ab_map_d;
   logic e_map_q, e_map_d;
   logic k_map_q, k_map_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic [31:0] status_w;
   logic setup;
   logic access;
   logic hit_mode;
   logic hit_status;
   logic wr_mode;
   logic special;
   logic [1:0] new_mod;

   // reset release through two flip-flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   strap_sync #(
      .WIDTH(3)
   ) u_strap_sync (
      .clk(clk),
      .rst_n(rst_sync_q),
      .pin_in({debug_strap_pin, mode_select_b, mode_select_a}),
      .pin_sync(strap_s)
   );

   // decode of the current mode register
   mode_decode u_mode_decode (
      .code(mode_q[mode_pkg::SPECIAL_MODE_N_BIT:mode_pkg::MODE_SELECT_A_BIT]),
      .cfg(cfg_now)
   );

   // apb phase decode
   assign setup = psel & ~penable;
   assign access = psel & penable & pready_q;
   // no mode register access in peripheral
   assign hit_mode = (paddr == ADDR_W'(mode_pkg::MODE_OFS)) & ~cfg_now.peripheral;
   assign hit_status = (paddr == ADDR_W'(mode_pkg::STATUS_OFS));
   assign wr_mode = access & pwrite & hit_mode;
   assign special = ~mode_q[mode_pkg::SPECIAL_MODE_N_BIT];
   assign new_mod = pwdata[mode_pkg::MODE_SELECT_B_BIT:mode_pkg::MODE_SELECT_A_BIT];

   // status word from block state
   always_comb begin
      status_w = '0;
      status_w[mode_pkg::ST_SPECIAL_BIT] = cfg_q.special;
      status_w[mode_pkg::ST_SINGLE_BIT] = cfg_q.single_chip;
      status_w[mode_pkg::ST_NARROW_BIT] = cfg_q.narrow;
      status_w[mode_pkg::ST_WIDE_BIT] = cfg_q.wide;
      status_w[mode_pkg::ST_PERIPH_BIT] = cfg_q.peripheral;
      status_w[mode_pkg::ST_AB_MAP_BIT] = ab_map_q;
      status_w[mode_pkg::ST_E_MAP_BIT] = e_map_q;
      status_w[mode_pkg::ST_K_MAP_BIT] = k_map_q;
      status_w[mode_pkg::ST_DBG_EN_BIT] = dbg_en_q;
      status_w[mode_pkg::ST_DBG_ACT_BIT] = dbg_act_q;
   end

   // mode register and debug state next values
   always_comb begin
      mode_d = mode_q;
      captured_d = captured_q;
      settle_d = settle_q;
      wr_seen_d = wr_seen_q;
      dbg_en_d = dbg_en_q;
      dbg_act_d = dbg_act_q;
      if (!captured_q && !settle_q[1]) begin
         // let the strap synchroniser fill after reset release
         settle_d = {settle_q[0], 1'b1};
      end else if (!captured_q) begin
         // catch the straps once after reset release
         captured_d = 1'b1;
         if (strap_s[2]) begin
            mode_d = mode_pkg::MODE_RST_NORMAL;
         end else begin
            mode_d = mode_pkg::MODE_RST_SPECIAL;
         end
         // mode bits at 7, 6 and 5
         mode_d[mode_pkg::SPECIAL_MODE_N_BIT:mode_pkg::MODE_SELECT_A_BIT] = strap_s;
         // special single chip starts in debug
         dbg_en_d = (strap_s == 3'h0);
         dbg_act_d = (strap_s == 3'h0);
      end else begin
         if (wr_mode) begin
            wr_seen_d = 1'b1;
            if (special) begin
               mode_d[mode_pkg::ESTR_BIT] = pwdata[mode_pkg::ESTR_BIT];
               if (wr_seen_q) begin
                  mode_d[mode_pkg::SPECIAL_MODE_N_BIT] = pwdata[mode_pkg::SPECIAL_MODE_N_BIT];
                  mode_d[mode_pkg::IVIS_BIT] = pwdata[mode_pkg::IVIS_BIT];
                  mode_d[mode_pkg::EMK_BIT] = pwdata[mode_pkg::EMK_BIT];
                  mode_d[mode_pkg::EME_BIT] = pwdata[mode_pkg::EME_BIT];
                  // special: any write but the first
                  if (new_mod != mode_pkg::MOD_FORBIDDEN) begin
                     mode_d[mode_pkg::MODE_SELECT_B_BIT:mode_pkg::MODE_SELECT_A_BIT] = new_mod;
                  end
               end
            end else begin
               mode_d[mode_pkg::EBSWAI_BIT] = pwdata[mode_pkg::EBSWAI_BIT];
               if (!wr_seen_q) begin
                  mode_d[mode_pkg::ESTR_BIT] = pwdata[mode_pkg::ESTR_BIT];
                  mode_d[mode_pkg::IVIS_BIT] = pwdata[mode_pkg::IVIS_BIT];
                  mode_d[mode_pkg::EMK_BIT] = pwdata[mode_pkg::EMK_BIT];
                  mode_d[mode_pkg::EME_BIT] = pwdata[mode_pkg::EME_BIT];
                  if (new_mod != mode_pkg::MOD_FORBIDDEN) begin
                     mode_d[mode_pkg::MODE_SELECT_B_BIT:mode_pkg::MODE_SELECT_A_BIT] = new_mod;
                  end
               end
            end
            // clock stretch kept on by any write made while a bus is already present
            if (!cfg_now.single_chip) begin
               mode_d[mode_pkg::ESTR_BIT] = 1'b1;
            end
         end
         if (debug_enable_cmd) begin
            dbg_en_d = 1'b1;
         end
         if (debug_activate_cmd && (dbg_en_q || debug_enable_cmd)) begin
            dbg_act_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         mode_q <= mode_pkg::MODE_PRE_CAPTURE;
         captured_q <= 1'b0;
         settle_q <= 2'h0;
         wr_seen_q <= 1'b0;
         dbg_en_q <= 1'b0;
         dbg_act_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         captured_q <= captured_d;
         settle_q <= settle_d;
         wr_seen_q <= wr_seen_d;
         dbg_en_q <= dbg_en_d;
         dbg_act_q <= dbg_act_d;
      end
   end

   // memory map presence for the port registers
   always_comb begin
      // ports A and B only in single chip
      ab_map_d = cfg_now.single_chip;
      // port E out in peripheral or emulated expanded
      e_map_d = cfg_now.single_chip | (~cfg_now.peripheral & ~mode_q[mode_pkg::EME_BIT]);
      // port K out in peripheral or emulated expanded
      k_map_d = cfg_now.single_chip | (~cfg_now.peripheral & ~mode_q[mode_pkg::EMK_BIT]);
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         cfg_q <= '0;
         ab_map_q <= 1'b1;
         e_map_q <= 1'b1;
         k_map_q <= 1'b1;
      end else begin
         // single chip has no external bus
         cfg_q <= cfg_now;
         ab_map_q <= ab_map_d;
         e_map_q <= e_map_d;
         k_map_q <= k_map_d;
      end
   end

   // apb answer prepared in setup, shown in access
   always_comb begin
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = '0;
      if (setup) begin
         pready_d = 1'b1;
         // unmapped reads give zero and an error
         if (hit_mode) begin
            prdata_d = {24'h000000, mode_q};
         end else if (hit_status) begin
            prdata_d = status_w;
            pslverr_d = pwrite;
         end else begin
            pslverr_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   // outputs straight from flip-flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign mode_reg = mode_q;
   assign cfg_out = cfg_q;
   assign port_ab_in_map = ab_map_q;
   assign port_e_in_map = e_map_q;
   assign port_k_in_map = k_map_q;
   assign mode_reg_in_map = ~cfg_q.peripheral;
   assign regs_protected = ~cfg_q.special;
   assign background_debug_mode = dbg_act_q;

   // checks on capture, decode, mode writes, port maps and bus errors
   chk_strap_capture: assert property (@(posedge clk) disable iff (!rst_sync_q)
      $rose(captured_q) |-> mode_q[7:5] == $past(strap_s))
      else $error("mode bits differ from straps at capture");

   chk_periph_decode: assert property (@(posedge clk) disable iff (!rst_sync_q)
      (mode_q[5:0] != 6'h0 && mode_q[6:5] == 2'h2) |=> cfg_q.peripheral && cfg_q.port_b_data)
      else $error("peripheral or reserved code not decoded as peripheral");

   chk_single_nobus: assert property (@(posedge clk) disable iff (!rst_sync_q)
      cfg_q.single_chip |-> !cfg_q.port_a_bus && !cfg_q.port_b_addr && ab_map_q)
      else $error("single chip mode shows an external bus");

   chk_narrow_bus: assert property (@(posedge clk) disable iff (!rst_sync_q)
      cfg_q.narrow |-> cfg_q.port_a_bus && cfg_q.port_b_addr && !cfg_q.port_b_data)
      else $error("narrow mode bus use wrong");

   chk_debug_start: assert property (@(posedge clk) disable iff (!rst_sync_q)
      $rose(captured_q) |-> background_debug_mode == (mode_q[7:5] == 3'h0))
      else $error("debug state at capture wrong");

   chk_normal_lock: assert property (@(posedge clk) disable iff (!rst_sync_q)
      (wr_mode && !special && wr_seen_q) |=> mode_q[6:3] == $past(mode_q[6:3]))
      else $error("normal mode accepted a second write");

   chk_first_ignored: assert property (@(posedge clk) disable iff (!rst_sync_q)
      (wr_mode && special && !wr_seen_q) |=> mode_q[7:5] == $past(mode_q[7:5]))
      else $error("special mode took its first write");

   chk_no_periph_entry: assert property (@(posedge clk) disable iff (!rst_sync_q)
      (captured_q && $past(captured_q)) |-> (cfg_now.peripheral == $past(cfg_now.peripheral)))
      else $error("peripheral mode changed without reset");

   chk_e_map: assert property (@(posedge clk) disable iff (!rst_sync_q)
      $past(captured_q) && cfg_q.peripheral |-> !e_map_q && !k_map_q && !ab_map_q)
      else $error("port registers left in map in peripheral mode");

   chk_k_emulate: assert property (@(posedge clk) disable iff (!rst_sync_q)
      (cfg_now.wide && mode_q[mode_pkg::EMK_BIT]) |=> !k_map_q)
      else $error("port k stays in map while emulated");

   chk_unmapped_err: assert property (@(posedge clk) disable iff (!rst_sync_q)
      (setup && !hit_mode && !hit_status) |=> pready_q && pslverr_q && prdata_q == 32'h0)
      else $error("unmapped access not answered with error");

endmodule

/* File: mode_host_model.sv */
// Purpose: far side model, strap pins and background debug host
// Assumes: straps are static levels; host commands are one-cycle pulses
// Notes: skip_enable makes the host activate without enabling first
module mode_host_model (
   // clock
   input wire logic clk,
   // requests from the bench
   input wire logic [2:0] strap_code,
   input wire logic dbg_go,
   input wire logic skip_enable,
   // strap pins
   output logic debug_strap_pin,
   output logic mode_select_b,
   output logic mode_select_a,
   // debug host commands
   output logic debug_enable_cmd = 1'b0,
   output logic debug_activate_cmd = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   logic go_q = 1'b0;

   // straps follow the requested mode code
   assign {debug_strap_pin, mode_select_b, mode_select_a} = strap_code;

   always @(posedge clk) begin
      debug_enable_cmd <= dbg_go & ~skip_enable;
      debug_activate_cmd <= go_q;
      go_q <= dbg_go;
   end
endmodule

/* File: operating_mode_select_test.sv */
// Purpose: self-checking bench for the operating mode selector
// Assumes: zero-wait apb slave, straps held across reset release
// Notes: every mode code is captured, decoded and read back
module operating_mode_select_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_n, psel, penable, pwrite, dbg_go, skip_enable, pready, pslverr;
   logic debug_strap_pin, mode_select_b, mode_select_a, debug_enable_cmd, debug_activate_cmd;
   logic port_ab_in_map, port_e_in_map, port_k_in_map, mode_reg_in_map, regs_protected;
   logic background_debug_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] strap_code;
   logic [7:0] mode_reg;
   mode_pkg::cfg_t cfg_out;
   int bad_count = 0;
   int tests_run = 0;

   // block and its far side
   operating_mode_select u_dut (.clk(clk), .rst_n(rst_n), .debug_strap_pin(debug_strap_pin),
      .mode_select_b(mode_select_b), .mode_select_a(mode_select_a),
      .debug_enable_cmd(debug_enable_cmd), .debug_activate_cmd(debug_activate_cmd),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_reg(mode_reg),
      .cfg_out(cfg_out), .port_ab_in_map(port_ab_in_map), .port_e_in_map(port_e_in_map),
      .port_k_in_map(port_k_in_map), .mode_reg_in_map(mode_reg_in_map),
      .regs_protected(regs_protected), .background_debug_mode(background_debug_mode));
   mode_host_model u_host (.clk(clk), .strap_code(strap_code), .dbg_go(dbg_go),
      .skip_enable(skip_enable), .debug_strap_pin(debug_strap_pin),
      .mode_select_b(mode_select_b), .mode_select_a(mode_select_a),
      .debug_enable_cmd(debug_enable_cmd), .debug_activate_cmd(debug_activate_cmd));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // reset value of the mode register for a captured code
   function automatic logic [7:0] exp_mode(input logic [2:0] c);
      return (c[2] ? 8'h10 : 8'h1B) | {c, 5'h00};
   endfunction

   // expected status word straight after capture
   function automatic logic [31:0] exp_status(input logic [2:0] c);
      logic per, sgl, emu_in;
      per = (c[1:0] == 2'b10);
      sgl = (c[1:0] == 2'b00);
      emu_in = sgl | (~per & c[2]);
      return {22'h0, c == 3'h0, c == 3'h0, emu_in, emu_in, sgl, per, c[1:0] == 2'b11,
         c[1:0] == 2'b01, sgl, ~c[2]};
   endfunction

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t bus answer timed out", $time);
         print_verdict();
      end
   endtask

   // write, then let the register and its decode settle
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
      repeat (2) @(posedge clk);
      check(32'(err), 32'(e), "write response");
   endtask

   task automatic do_reset(input logic [2:0] c);
      @(posedge clk);
      rst_n <= 1'b0;
      strap_code <= c;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask

   // every strap code: capture, decode, maps and readback
   task automatic t_modes();
      logic [31:0] rd, st, mask;
      logic err, per, sgl;
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         per = (c[1:0] == 2'b10);
         sgl = (c[1:0] == 2'b00);
         st = exp_status(c);
         mask = (c == 3'h6) ? 32'h0000_03FE : 32'h0000_03FF;
         do_reset(c);
         check(32'(mode_reg), 32'(exp_mode(c)), "captured mode");
         check(32'(cfg_out.single_chip), 32'(sgl), "single chip");
         check(32'(cfg_out.peripheral), 32'(per), "peripheral");
         check(32'(cfg_out.wide), 32'(c[1:0] == 2'b11), "wide");
         check(32'(cfg_out.port_a_bus), 32'(!sgl), "port a bus");
         check(32'(cfg_out.port_b_data), 32'(c[1]), "port b data");
         check(32'(port_ab_in_map), 32'(sgl), "port ab map");
         check(32'(port_e_in_map), 32'(st[6]), "port e map");
         check(32'(port_k_in_map), 32'(st[7]), "port k map");
         check(32'(background_debug_mode), 32'(c == 3'h0), "debug active");
         check(32'(mode_reg_in_map), 32'(!per), "mode reg map");
         if (c != 3'h6) begin
            check(32'(regs_protected), 32'(c[2]), "protection");
         end
         apb(1'b0, mode_pkg::STATUS_OFS, 32'h0, rd, err);
         check(rd & mask, st & mask, "status");
         apb(1'b0, mode_pkg::MODE_OFS, 32'h0, rd, err);
         check(32'(err), 32'(per), "mode read refusal");
         if (!per) begin
            check(rd, 32'(exp_mode(c)), "mode readback");
         end else begin
            wr(mode_pkg::MODE_OFS, 32'h0000_0000, 1'b1);
            check(32'(mode_reg), 32'(exp_mode(c)), "peripheral kept");
         end
      end
   endtask

   // normal mode: fields written once, bus stop bit any time
   task automatic t_normal();
      do_reset(3'h4);
      wr(mode_pkg::MODE_OFS, 32'h0000_00B4, 1'b0);
      check(32'(mode_reg), 32'h0000_00B4, "normal first write");
      check(32'(cfg_out.narrow), 32'h1, "narrow decode");
      check(32'(cfg_out.port_b_addr), 32'h1, "port b address");
      wr(mode_pkg::MODE_OFS, 32'h0000_00E0, 1'b0);
      check(32'(mode_reg), 32'h0000_00B0, "normal second write");
   endtask

   // special mode: first write ignored, peripheral code refused
   task automatic t_special();
      do_reset(3'h0);
      wr(mode_pkg::MODE_OFS, 32'h0000_007B, 1'b0);
      check(32'(mode_reg), 32'h0000_001B, "first write ignored");
      wr(mode_pkg::MODE_OFS, 32'h0000_005B, 1'b0);
      check(32'(mode_reg), 32'h0000_001B, "peripheral refused");
      wr(mode_pkg::MODE_OFS, 32'h0000_003F, 1'b0);
      check(32'(mode_reg), 32'h0000_003B, "special narrow");
      check(32'(port_ab_in_map), 32'h0, "ab out of map");
      check(32'(port_e_in_map), 32'h0, "e emulated");
      check(32'(port_k_in_map), 32'h0, "k emulated");
      wr(mode_pkg::MODE_OFS, 32'h0000_00BB, 1'b0);
      check(32'(mode_reg), 32'h0000_00BB, "leave special");
      check(32'(regs_protected), 32'h1, "now protected");
   endtask

   // unmapped read and read-only write are refused
   task automatic t_errors();
      logic [31:0] rd;
      logic err;
      do_reset(3'h4);
      apb(1'b0, 12'h008, 32'h0, rd, err);
      check(32'(err), 32'h1, "unmapped read");
      wr(mode_pkg::STATUS_OFS, 32'h0000_03FF, 1'b1);
   endtask

   task automatic dbg_cmd(input logic skip);
      @(posedge clk);
      skip_enable <= skip;
      dbg_go <= 1'b1;
      @(posedge clk);
      dbg_go <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // normal mode: activation needs enable first
   task automatic t_debug();
      do_reset(3'h4);
      check(32'(background_debug_mode), 32'h0, "debug idle");
      dbg_cmd(1'b1);
      check(32'(background_debug_mode), 32'h0, "activate alone");
      dbg_cmd(1'b0);
      check(32'(background_debug_mode), 32'h1, "enable then activate");
   endtask

   // main sequence
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      dbg_go = 1'b0;
      skip_enable = 1'b0;
      strap_code = 3'h4;
      t_modes();
      t_normal();
      t_special();
      t_errors();
      t_debug();
      print_verdict();
   end
endmodule
